// ===== hdl/ssi_defs.svh
// Register offsets, field positions, reset values and key for the sync serial block
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH

`define SSI_WORD_W 16
`define SSI_FSL_W 4

`define SSI_OFF_CTRL 32'hf0010050
`define SSI_OFF_RX_HOLD 32'hf0010020
`define SSI_OFF_TX_HOLD 32'hf0010024
`define SSI_OFF_RX_SYNC 32'hf0010030
`define SSI_OFF_TX_SYNC 32'hf0010034
`define SSI_OFF_CMP_A 32'hf0010038
`define SSI_OFF_CMP_B 32'hf001003c
`define SSI_OFF_STATUS 32'hf0010040
`define SSI_OFF_IRQ_SET 32'hf0010044
`define SSI_OFF_IRQ_CLR 32'hf0010048
`define SSI_OFF_IRQ_MASK 32'hf001004c
`define SSI_OFF_WLOCK 32'hf00100e4

`define SSI_B_TX_HOLDING_FREE 0
`define SSI_B_TX_ALL_DONE 1
`define SSI_B_RX_WORD_AVAILABLE 4
`define SSI_B_OVR 5
`define SSI_B_CMPA 8
`define SSI_B_CMPB 9
`define SSI_B_TX_FRAME_EVENT 10
`define SSI_B_RX_FRAME_EVENT 11
`define SSI_B_TXON 16
`define SSI_B_RXON 17

`define SSI_CTRL_TXON 0
`define SSI_CTRL_RXON 1
`define SSI_CTRL_FSD 2
`define SSI_CTRL_FSL_LO 4

`define SSI_IRQ_BITS 12'hf33
`define SSI_WP_KEY 24'h535343
`define SSI_FSL_RST 4'h0

`endif

// ===== hdl/ssi_pkg.sv
// Types of the sync serial status and interrupt block
`include "ssi_defs.svh"

package ssi_pkg;

  typedef enum logic [1:0] {PH_IDLE, PH_SYNC, PH_DATA} ssi_phase_t;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_p;
    logic rxd_s1;
    logic rxd_s2;
    logic rfs_s1;
    logic rfs_s2;
    logic tx_on;
    logic rx_on;
    logic fsd_on;
    logic [`SSI_FSL_W-1:0] fs_len;
    logic wlock;
    logic [`SSI_WORD_W-1:0] tx_hold;
    logic tx_full;
    logic [`SSI_WORD_W-1:0] tx_sh;
    logic [`SSI_WORD_W-1:0] tx_ts;
    ssi_phase_t tx_ph;
    logic [4:0] tx_cnt;
    logic tx_data;
    logic tx_frame;
    logic [`SSI_WORD_W-1:0] rx_sh;
    ssi_phase_t rx_ph;
    logic [4:0] rx_cnt;
    logic [`SSI_WORD_W-1:0] rx_hold;
    logic rx_full;
    logic ovr;
    logic cmp_a_f;
    logic cmp_b_f;
    logic tx_frame_event;
    logic rx_frame_event;
    logic [`SSI_WORD_W-1:0] tsync;
    logic [`SSI_WORD_W-1:0] rsync;
    logic [`SSI_WORD_W-1:0] cmp_a;
    logic [`SSI_WORD_W-1:0] cmp_b;
    logic [11:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } ssi_state_t;

endpackage

// ===== hdl/ssi_regs.sv
// Sync serial status, interrupt and sync-data registers with a simple shifter
//
// Summary of operation
// [RULE_01] Bit 0 low while transmit holding word waits
// [RULE_02] Bit 1 set once last word fully sent
// [RULE_03] Bit 4 set while receive holding word unread
// [RULE_04] Bit 5 marks overwrite; cleared by status read
// [RULE_05] Bit 8 latches compare A; read clears
// [RULE_06] Bit 9 latches compare B; read clears
// [RULE_07] Bit 10 latches transmit sync; read clears
// [RULE_08] Bit 11 latches receive sync; read clears
// [RULE_09] Bits 16/17 show transmitter/receiver enable
// [RULE_10] Enable-set register sets written mask bits
// [RULE_11] Enable-clear register clears written mask bits
// [RULE_12] Mask readable with status bit layout
// [RULE_13] Compare registers writable only when unlocked
// [RULE_14] Received sync value read-only, bits 15:0
// [RULE_15] Transmit sync value read/write, bits 15:0
// [RULE_16] Compare A value, bits 15:0
// [RULE_17] Compare B value, bits 15:0
// [RULE_18] Lock bit changes only with correct key
// [RULE_19] Sync value shifted out during frame pulse
// [RULE_20] Interrupt when any flag and mask set
// [RULE_21] Compare event on matching sync/data word
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssi_defs.svh"

module ssi_regs (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link pins
  input wire logic ser_clk,
  input wire logic rx_data,
  input wire logic rx_frame,
  output logic tx_data,
  output logic tx_frame,
  // Interrupt
  output logic irq
);
  import ssi_pkg::*;

  ssi_state_t s_q;
  ssi_state_t s_d;

  // Status word as software reads it; the interrupt uses the same view
  function automatic logic [31:0] stat_vec(input ssi_state_t s);
    logic [31:0] v;
    v = 32'h0;
    v[`SSI_B_TX_HOLDING_FREE] = ~s.tx_full; // RULE_01
    v[`SSI_B_TX_ALL_DONE] = ~s.tx_full & (s.tx_ph == PH_IDLE); // RULE_02
    v[`SSI_B_RX_WORD_AVAILABLE] = s.rx_full; // RULE_03
    v[`SSI_B_OVR] = s.ovr;
    v[`SSI_B_CMPA] = s.cmp_a_f;
    v[`SSI_B_CMPB] = s.cmp_b_f;
    v[`SSI_B_TX_FRAME_EVENT] = s.tx_frame_event;
    v[`SSI_B_RX_FRAME_EVENT] = s.rx_frame_event;
    v[`SSI_B_TXON] = s.tx_on; // RULE_09
    v[`SSI_B_RXON] = s.rx_on; // RULE_09
    return v;
  endfunction

  // Mapped offsets; all others answer with an error and read as zero
  function automatic logic addr_hit(input logic [31:0] a);
    case (a)
      `SSI_OFF_CTRL, `SSI_OFF_RX_HOLD, `SSI_OFF_TX_HOLD, `SSI_OFF_RX_SYNC,
      `SSI_OFF_TX_SYNC, `SSI_OFF_CMP_A, `SSI_OFF_CMP_B, `SSI_OFF_STATUS,
      `SSI_OFF_IRQ_SET, `SSI_OFF_IRQ_CLR, `SSI_OFF_IRQ_MASK, `SSI_OFF_WLOCK:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    logic setup;
    logic done;
    logic wr;
    logic rd;
    logic rise;
    logic fall;
    logic cmp_v;
    logic [`SSI_WORD_W-1:0] cmp_w;
    logic [`SSI_WORD_W-1:0] rx_new;
    logic [31:0] rv;
    logic [31:0] st;
    setup = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    cmp_v = 1'b0;
    cmp_w = '0;
    rx_new = '0;
    rv = 32'h0;
    st = 32'h0;
    // One copy of the whole state, filled in order of priority; later
    // sections overwrite earlier ones, so a set wins over a read-clear
    s_d = s_q;

    // Pin synchronisers
    // Reset leaves the stored link clock low, so an idle-high clock shows one
    // rise after release; the receiver is still off then and ignores it
    s_d.sclk_s1 = ser_clk;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_p = s_q.sclk_s2;
    s_d.rxd_s1 = rx_data;
    s_d.rxd_s2 = s_q.rxd_s1;
    s_d.rfs_s1 = rx_frame;
    s_d.rfs_s2 = s_q.rfs_s1;
    rise = s_q.sclk_s2 & ~s_q.sclk_p;
    fall = ~s_q.sclk_s2 & s_q.sclk_p;

    // APB: answer in the first access cycle
    // Read data is captured at the setup edge; the read-clear below uses the
    // same snapshot, so software never loses a flag it was not shown
    setup = psel & ~penable;
    done = psel & penable & s_q.pready;
    wr = done & pwrite;
    rd = done & ~pwrite;
    s_d.pready = setup;
    s_d.pslverr = setup & ~addr_hit(paddr);
    if (setup & ~pwrite)
    begin
      case (paddr)
        `SSI_OFF_CTRL:
        begin
          rv[`SSI_CTRL_TXON] = s_q.tx_on;
          rv[`SSI_CTRL_RXON] = s_q.rx_on;
          rv[`SSI_CTRL_FSD] = s_q.fsd_on;
          rv[`SSI_CTRL_FSL_LO +: `SSI_FSL_W] = s_q.fs_len;
        end
        `SSI_OFF_RX_HOLD: rv[`SSI_WORD_W-1:0] = s_q.rx_hold;
        `SSI_OFF_RX_SYNC: rv[`SSI_WORD_W-1:0] = s_q.rsync; // RULE_14
        `SSI_OFF_TX_SYNC: rv[`SSI_WORD_W-1:0] = s_q.tsync; // RULE_15
        `SSI_OFF_CMP_A: rv[`SSI_WORD_W-1:0] = s_q.cmp_a; // RULE_16
        `SSI_OFF_CMP_B: rv[`SSI_WORD_W-1:0] = s_q.cmp_b; // RULE_17
        `SSI_OFF_STATUS: rv = stat_vec(s_q);
        `SSI_OFF_IRQ_MASK: rv[11:0] = s_q.mask; // RULE_12
        `SSI_OFF_WLOCK: rv[0] = s_q.wlock;
        default: rv = 32'h0;
      endcase
    end
    s_d.prdata = rv;

    // Status read side effects clear only what the read reported; a holding read frees the register outright
    // An event in the access cycle itself is kept for the next read
    if (rd && paddr == `SSI_OFF_STATUS)
    begin
      s_d.ovr = s_q.ovr & ~s_q.prdata[`SSI_B_OVR]; // RULE_04
      s_d.cmp_a_f = s_q.cmp_a_f & ~s_q.prdata[`SSI_B_CMPA]; // RULE_05
      s_d.cmp_b_f = s_q.cmp_b_f & ~s_q.prdata[`SSI_B_CMPB]; // RULE_06
      s_d.tx_frame_event = s_q.tx_frame_event & ~s_q.prdata[`SSI_B_TX_FRAME_EVENT]; // RULE_07
      s_d.rx_frame_event = s_q.rx_frame_event & ~s_q.prdata[`SSI_B_RX_FRAME_EVENT]; // RULE_08
    end
    if (rd && paddr == `SSI_OFF_RX_HOLD)
    begin
      s_d.rx_full = 1'b0;
    end

    // Transmitter, stepped on falling link clock
    // The holding register frees at frame start; a word written during the
    // frame waits for the next one
    if (fall)
    begin
      case (s_q.tx_ph)
        PH_IDLE:
        begin
          s_d.tx_data = 1'b0;
          if (s_q.tx_on & s_q.tx_full)
          begin
            s_d.tx_sh = s_q.tx_hold;
            s_d.tx_full = 1'b0; // RULE_01
            s_d.tx_ts = s_q.tsync << 1;
            s_d.tx_data = s_q.fsd_on & s_q.tsync[`SSI_WORD_W-1]; // RULE_19
            s_d.tx_cnt = {1'b0, s_q.fs_len};
            s_d.tx_frame = 1'b1;
            s_d.tx_frame_event = 1'b1; // RULE_07
            s_d.tx_ph = PH_SYNC;
          end
        end
        PH_SYNC:
        begin
          if (s_q.tx_cnt == 5'h0)
          begin
            s_d.tx_frame = 1'b0;
            s_d.tx_data = s_q.tx_sh[`SSI_WORD_W-1];
            s_d.tx_sh = s_q.tx_sh << 1;
            s_d.tx_cnt = 5'(`SSI_WORD_W - 1);
            s_d.tx_ph = PH_DATA;
          end
          else
          begin
            // Without frame-sync data the line rests low during the pulse
            s_d.tx_data = s_q.fsd_on & s_q.tx_ts[`SSI_WORD_W-1]; // RULE_19
            s_d.tx_ts = s_q.tx_ts << 1;
            s_d.tx_cnt = s_q.tx_cnt - 5'h1;
          end
        end
        PH_DATA:
        begin
          if (s_q.tx_cnt == 5'h0)
          begin
            // Tx-empty rises here, one bit time after the last data bit began
            s_d.tx_data = 1'b0;
            s_d.tx_ph = PH_IDLE; // RULE_02
          end
          else
          begin
            s_d.tx_data = s_q.tx_sh[`SSI_WORD_W-1];
            s_d.tx_sh = s_q.tx_sh << 1;
            s_d.tx_cnt = s_q.tx_cnt - 5'h1;
          end
        end
        default:
          s_d.tx_ph = PH_IDLE;
      endcase
    end

    // Receiver, sampled on rising link clock
    // Bits seen while the frame pulse is high form the sync value; the newest
    // bit lands in bit 0 and only the last sixteen are kept
    if (rise)
    begin
      rx_new = {s_q.rx_sh[`SSI_WORD_W-2:0], s_q.rxd_s2};
      case (s_q.rx_ph)
        PH_IDLE:
        begin
          // Frame pulses are only looked for between words
          if (s_q.rx_on & s_q.rfs_s2)
          begin
            s_d.rx_frame_event = 1'b1; // RULE_08
            s_d.rx_sh = {{(`SSI_WORD_W-1){1'b0}}, s_q.rxd_s2};
            s_d.rx_ph = PH_SYNC;
          end
        end
        PH_SYNC:
        begin
          if (s_q.rfs_s2)
          begin
            s_d.rx_sh = rx_new;
          end
          else
          begin
            s_d.rsync = s_q.rx_sh; // RULE_14
            cmp_v = 1'b1;
            cmp_w = s_q.rx_sh;
            s_d.rx_sh = {{(`SSI_WORD_W-1){1'b0}}, s_q.rxd_s2};
            s_d.rx_cnt = 5'(`SSI_WORD_W - 2);
            s_d.rx_ph = PH_DATA;
          end
        end
        PH_DATA:
        begin
          s_d.rx_sh = rx_new;
          if (s_q.rx_cnt == 5'h0)
          begin
            s_d.rx_hold = rx_new;
            // A word landing on an unread one marks the overrun; a holding
            // read in the same cycle frees the register first
            s_d.ovr = s_d.ovr | s_d.rx_full; // RULE_04
            s_d.rx_full = 1'b1; // RULE_03
            cmp_v = 1'b1;
            cmp_w = rx_new;
            s_d.rx_ph = PH_IDLE;
          end
          else
          begin
            s_d.rx_cnt = s_q.rx_cnt - 5'h1;
          end
        end
        default:
          s_d.rx_ph = PH_IDLE;
      endcase
    end

    // Compare events
    // Both the sync value and every data word are compared, against the
    // registers as they stood before this cycle's writes
    if (cmp_v && cmp_w == s_q.cmp_a)
    begin
      s_d.cmp_a_f = 1'b1; // RULE_21 RULE_05
    end
    if (cmp_v && cmp_w == s_q.cmp_b)
    begin
      s_d.cmp_b_f = 1'b1; // RULE_21 RULE_06
    end

    // Register writes at the completing access edge
    // Locked compare writes and wrong-key lock writes are dropped silently
    if (wr)
    begin
      case (paddr)
        // Control word: enables, frame-sync data and frame pulse length
        `SSI_OFF_CTRL:
        begin
          s_d.tx_on = pwdata[`SSI_CTRL_TXON];
          s_d.rx_on = pwdata[`SSI_CTRL_RXON];
          s_d.fsd_on = pwdata[`SSI_CTRL_FSD];
          s_d.fs_len = pwdata[`SSI_CTRL_FSL_LO +: `SSI_FSL_W];
        end
        `SSI_OFF_TX_HOLD:
        begin
          s_d.tx_hold = pwdata[`SSI_WORD_W-1:0];
          s_d.tx_full = 1'b1; // RULE_01
        end
        `SSI_OFF_TX_SYNC: s_d.tsync = pwdata[`SSI_WORD_W-1:0]; // RULE_15
        `SSI_OFF_CMP_A:
        begin
          if (!s_q.wlock)
          begin
            s_d.cmp_a = pwdata[`SSI_WORD_W-1:0]; // RULE_13 RULE_16
          end
        end
        `SSI_OFF_CMP_B:
        begin
          if (!s_q.wlock)
          begin
            s_d.cmp_b = pwdata[`SSI_WORD_W-1:0]; // RULE_13 RULE_17
          end
        end
        `SSI_OFF_IRQ_SET: s_d.mask = s_q.mask | pwdata[11:0]; // RULE_10
        `SSI_OFF_IRQ_CLR: s_d.mask = s_q.mask & ~pwdata[11:0]; // RULE_11
        `SSI_OFF_WLOCK:
        begin
          if (pwdata[31:8] == `SSI_WP_KEY)
          begin
            s_d.wlock = pwdata[0]; // RULE_18
          end
        end
        // Read-only and unmapped offsets change nothing
        default: s_d.mask = s_d.mask;
      endcase
    end
    // Mask positions with no status flag behind them stay zero
    s_d.mask = s_d.mask & `SSI_IRQ_BITS;

    // Interrupt follows the registered flags, so it lags them by one clock
    st = stat_vec(s_q);
    s_d.irq = |(st[11:0] & s_q.mask); // RULE_20
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Every output comes straight from a state flip-flop
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign tx_data = s_q.tx_data;
  assign tx_frame = s_q.tx_frame;
  assign irq = s_q.irq;

endmodule
`default_nettype wire

// ===== test/ssi_asserts.sv
// Port-level checks of the sync serial register block
`timescale 1ns/1ps
`default_nettype none
`include "ssi_defs.svh"

module ssi_asserts (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and interrupt
  input wire logic ser_clk,
  input wire logic rx_data,
  input wire logic rx_frame,
  input wire logic tx_data,
  input wire logic tx_frame,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = psel && penable && pready && !pwrite;
  wire logic wr = psel && penable && pready && pwrite;

  rdy_setup_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in first access cycle");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
  sync_rsvd_a: assert property (
    rd && paddr[31:4] == 28'hf001003 |-> prdata[31:16] == 16'h0)
    else $error("upper bits of sync value set");
  status_map_a: assert property (
    rd && paddr == `SSI_OFF_STATUS |-> (prdata & 32'hfffcf0cc) == 32'h0)
    else $error("status reserved bits set");
  mask_map_a: assert property (
    rd && paddr == `SSI_OFF_IRQ_MASK |-> (prdata & 32'hfffff0cc) == 32'h0)
    else $error("mask reserved bits set");
  tx_order_a: assert property (
    rd && paddr == `SSI_OFF_STATUS && prdata[1] |-> prdata[0])
    else $error("tx empty while holding busy");
  irq_clear_a: assert property (
    wr && paddr == `SSI_OFF_IRQ_CLR && (pwdata[11:0] & 12'hf33) == 12'hf33 |=> ##1 !irq)
    else $error("interrupt after full mask clear");
endmodule

bind ssi_regs ssi_asserts ssi_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .ser_clk, .rx_data, .rx_frame, .tx_data, .tx_frame,
  .irq);
`default_nettype wire

// ===== test/ssi_peer.sv
// Far-side codec model: clocks the link only while a transfer runs
`timescale 1ns/1ps
`default_nettype none

module ssi_peer (
  // Link pins
  output logic ser_clk,
  output logic rx_data,
  output logic rx_frame,
  input wire logic tx_data,
  input wire logic tx_frame
);
  logic [33:0] cap_f;
  logic [33:0] cap_d;

  initial
  begin
    ser_clk = 1'b1;
    rx_data = 1'b0;
    rx_frame = 1'b0;
  end

  // 16 sync bits with frame high, 16 data bits, 2 idle bits; clock rests high after
  task automatic xfer(input logic [15:0] sy, input logic [15:0] wd);
    logic [31:0] bits;
    bits = {sy, wd};
    #7;
    for (int i = 0; i < 34; i++)
    begin
      ser_clk = 1'b0;
      rx_frame = (i < 16);
      rx_data = (i < 32) ? bits[31 - i] : ~rx_data;
      #100 ser_clk = 1'b1;
      #99;
      // Sample at end of period, well after the device has moved its outputs
      cap_f = {cap_f[32:0], tx_frame};
      cap_d = {cap_d[32:0], tx_data};
      #1;
    end
  endtask
endmodule
`default_nettype wire

// ===== test/ssi_regs_bench.sv
// Self-checking bench for the sync serial register block
`timescale 1ns/1ps
`default_nettype none
`include "ssi_defs.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end

module ssi_regs_bench;
  logic pclk, presetn, psel, penable, pwrite, perr;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, ser_clk, rx_data, rx_frame, tx_data, tx_frame, irq;
  int n_tests = 0;
  int bad_count = 0;
  logic [31:0] lk [4] = '{32'h12345601, 32'h53534301, 32'h0, 32'h53534300};
  logic [3:0] lkx = 4'b0110;
  logic [15:0] ca = 16'h0;

  ssi_regs ssi_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ser_clk, .rx_data, .rx_frame, .tx_data, .tx_frame, .irq);
  ssi_peer ssi_peer_i (.ser_clk, .rx_data, .rx_frame, .tx_data, .tx_frame);

  task end_of_test;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge; one idle cycle after it
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    `CHK("pready", 1'b1, pready)
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK($sformatf("reg %h", a), e, r)
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    #1250000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`SSI_OFF_STATUS, 32'h3);
    rdc(`SSI_OFF_IRQ_MASK, 32'h0);
    rdc(32'hf0010000, 32'h0);
    `CHK("slverr", 1'b1, perr)
    foreach (lk[i])
    begin
      wr(`SSI_OFF_WLOCK, lk[i]);
      rdc(`SSI_OFF_WLOCK, {31'h0, lkx[i]});
      wr(`SSI_OFF_CMP_A, {16'h0, 8'h77, i[7:0]});
      if (!lkx[i])
        ca = {8'h77, i[7:0]};
      rdc(`SSI_OFF_CMP_A, {16'h0, ca});
    end
    wr(`SSI_OFF_IRQ_SET, 32'hffffffff);
    rdc(`SSI_OFF_IRQ_MASK, 32'hf33);
    `CHK("irq", 1'b1, irq)
    wr(`SSI_OFF_IRQ_CLR, 32'h00000f03);
    rdc(`SSI_OFF_IRQ_MASK, 32'h030);
    `CHK("irq", 1'b0, irq)
    wr(`SSI_OFF_CTRL, 32'hf7);
    rdc(`SSI_OFF_STATUS, 32'h30003);
    wr(`SSI_OFF_TX_SYNC, 32'hffffa5c3);
    rdc(`SSI_OFF_TX_SYNC, 32'ha5c3);
    wr(`SSI_OFF_CMP_A, 32'h1e2d);
    wr(`SSI_OFF_CMP_B, 32'h96f0);
    rdc(`SSI_OFF_CMP_B, 32'h96f0);
    wr(`SSI_OFF_TX_HOLD, 32'h3c5a);
    rdc(`SSI_OFF_STATUS, 32'h30000);
    ssi_peer_i.xfer(16'h1e2d, 16'h96f0);
    @(posedge pclk);
    `CHK("frame", {16'hffff, 18'h0}, ssi_peer_i.cap_f)
    `CHK("txd", {16'ha5c3, 16'h3c5a, 2'b00}, ssi_peer_i.cap_d)
    rdc(`SSI_OFF_STATUS, 32'h30f13);
    rdc(`SSI_OFF_STATUS, 32'h30013);
    rdc(`SSI_OFF_RX_SYNC, 32'h1e2d);
    rdc(`SSI_OFF_RX_HOLD, 32'h96f0);
    rdc(`SSI_OFF_STATUS, 32'h30003);
    ssi_peer_i.xfer(16'h1e2d, 16'h96f0);
    ssi_peer_i.xfer(16'h1e2d, 16'h96f0);
    @(posedge pclk);
    rdc(`SSI_OFF_STATUS, 32'h30b33);
    rdc(`SSI_OFF_STATUS, 32'h30013);
    `CHK("irq", 1'b1, irq)
    rdc(`SSI_OFF_RX_HOLD, 32'h96f0);
    @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    wr(`SSI_OFF_CTRL, 32'h33);
    wr(`SSI_OFF_TX_HOLD, 32'hc3a5);
    ssi_peer_i.xfer(16'h0, 16'h1234);
    @(posedge pclk);
    `CHK("frame", {4'hf, 30'h0}, ssi_peer_i.cap_f)
    `CHK("txd", {4'h0, 16'hc3a5, 14'h0}, ssi_peer_i.cap_d)
    rdc(`SSI_OFF_STATUS, 32'h30c13);
    rdc(`SSI_OFF_RX_HOLD, 32'h1234);
    wr(`SSI_OFF_IRQ_CLR, 32'hffffffff);
    rdc(`SSI_OFF_IRQ_MASK, 32'h0);
    wr(`SSI_OFF_CTRL, 32'h0);
    rdc(`SSI_OFF_STATUS, 32'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
